// >>> logic/urt_device.sv
`default_nettype none
module urt_device
  import urt_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  urt_bus_if.device bus,
  input wire logic rx_in,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic cd_n,
  input wire logic ri_n,
  output logic tx_out,
  output logic rts_n,
  output logic dtr_n
);
  typedef enum logic [1:0] {T_IDLE, T_SHIFT} urt_tx_type;
  typedef enum logic [1:0] {R_IDLE, R_SHIFT} urt_rx_type;

  ////////////////////////////////////////////////////////////////
  // Synchronisers: first stage read only by second
  logic [2:0] s1_ff, s2_ff, s3_ff; // {cs,rd,wr}
  logic rx1_ff, rx2_ff, cts1_ff, cts2_ff;
  logic rst1_ff, rst2_ff;
  wire logic [2:0] raw_strobes = {bus.cs_n, bus.read_strobe_n, bus.write_strobe_n};
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_ff <= 3'h7;
      s2_ff <= 3'h7;
      s3_ff <= 3'h7;
      rx1_ff <= 1'b1;
      rx2_ff <= 1'b1;
      cts1_ff <= 1'b1;
      cts2_ff <= 1'b1;
      rst1_ff <= 1'b0;
      rst2_ff <= 1'b0;
    end else if (ce) begin
      // Power-save freezes only the first strobe sync stage; all other flops keep switching
      if (!bus.bus_isolate_in) begin
        s1_ff <= raw_strobes;
      end
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      rx1_ff <= rx_in;
      rx2_ff <= rx1_ff;
      cts1_ff <= cts_n;
      cts2_ff <= cts1_ff;
      rst1_ff <= bus.hw_reset;
      rst2_ff <= rst1_ff;
    end
  end

  // Chip select seen at the same sync stage as the strobes
  wire logic sel_ok = !s2_ff[2];
  wire logic rd_fall = sel_ok && s3_ff[1] && !s2_ff[1];
  wire logic rd_rise = !s3_ff[1] && s2_ff[1];
  wire logic wr_rise = sel_ok && !s3_ff[0] && s2_ff[0];
  wire logic srst = rst2_ff; // Active-high device reset

  ////////////////////////////////////////////////////////////////
  // Register file and read path
  logic [7:0] mcr_ff, nxt_mcr, ier_ff, nxt_ier, efr_ff, nxt_efr;
  logic [7:0] rdat_ff, nxt_rdat;
  logic oe_ff, nxt_oe;
  logic [1:0] buf_cnt_ff, nxt_buf_cnt;
  logic [DATA_W-1:0] buf_ff [2];
  logic [DATA_W-1:0] nxt_buf [2];
  logic [DATA_W-1:0] rxd_ff, nxt_rxd;
  logic rxv_ff, nxt_rxv;
  logic buf_pop, buf_ready, rx_done;
  logic [7:0] modem_status_reg;
  logic [7:0] lsr;

  // Modem status mirrors input pins inverted
  always_comb begin
    modem_status_reg = RESET_BYTE;
    modem_status_reg[MS_CTS] = !cts2_ff;
    modem_status_reg[MS_DSR] = !dsr_n;
    modem_status_reg[MS_RI] = !ri_n;
    modem_status_reg[MS_CD] = !cd_n;
    lsr = RESET_BYTE;
    lsr[ST_TX_EMPTY] = buf_cnt_ff == 2'h0;
    lsr[ST_RX_READY] = rxv_ff;
  end

  // Two-entry transmit buffer; full refuses writes to data
  assign buf_ready = buf_cnt_ff != 2'h2;

  always_comb begin
    nxt_mcr = mcr_ff;
    nxt_ier = ier_ff;
    nxt_efr = efr_ff;
    nxt_rdat = rdat_ff;
    nxt_oe = oe_ff;
    nxt_buf = buf_ff;
    nxt_buf_cnt = buf_cnt_ff;
    nxt_rxv = rxv_ff;
    if (buf_pop) begin
      nxt_buf[0] = buf_ff[1];
      nxt_buf_cnt = buf_cnt_ff - 2'h1;
    end
    if (rd_fall) begin
      nxt_oe = 1'b1; // Drive only during reads
      case (bus.reg_select)
        SEL_DATA: begin
          nxt_rdat = rxd_ff;
          nxt_rxv = 1'b0;
        end
        SEL_IRQ_EN: nxt_rdat = ier_ff;
        SEL_MODEM_CTRL: nxt_rdat = mcr_ff;
        SEL_STATUS: nxt_rdat = lsr;
        SEL_MODEM_STAT: nxt_rdat = modem_status_reg;
        SEL_FEATURE: nxt_rdat = efr_ff;
        default: nxt_rdat = RESET_BYTE;
      endcase
    end
    if (rd_rise || s2_ff[2]) begin
      nxt_oe = 1'b0; // Release bus at strobe rise or deselect
    end
    if (wr_rise) begin
      case (bus.reg_select)
        SEL_DATA: begin
          if (buf_ready) begin
            nxt_buf[nxt_buf_cnt[0]] = bus.data_host;
            nxt_buf_cnt = nxt_buf_cnt + 2'h1;
          end
        end
        SEL_IRQ_EN: nxt_ier = bus.data_host;
        SEL_MODEM_CTRL: nxt_mcr = bus.data_host;
        SEL_FEATURE: nxt_efr = bus.data_host;
        default: nxt_mcr = mcr_ff;
      endcase
    end
    if (rx_done) begin
      nxt_rxv = 1'b1; // Set wins over read clear
    end
  end

  ////////////////////////////////////////////////////////////////
  // Transmitter: 16 ticks per bit, infrared short pulse
  urt_tx_type tst_ff, nxt_tst;
  logic [9:0] tsh_ff, nxt_tsh;
  logic [4:0] tcnt_ff, nxt_tcnt;
  logic [3:0] tbit_ff, nxt_tbit;
  logic txo_ff, nxt_txo;
  wire logic ir_mode = mcr_ff[MC_IR_SEL];
  // Auto clear-to-send holds start while pin deasserted
  wire logic cts_block = efr_ff[EF_AUTO_CTS] && cts2_ff;

  always_comb begin
    nxt_tst = tst_ff;
    nxt_tsh = tsh_ff;
    nxt_tcnt = tcnt_ff;
    nxt_tbit = tbit_ff;
    buf_pop = 1'b0;
    case (tst_ff)
      T_IDLE: begin
        if (buf_cnt_ff != 2'h0 && !cts_block) begin
          buf_pop = 1'b1;
          nxt_tsh = {1'b1, buf_ff[0], 1'b0};
          nxt_tst = T_SHIFT;
          nxt_tcnt = 5'h0;
          nxt_tbit = 4'h0;
        end
      end
      T_SHIFT: begin
        nxt_tcnt = tcnt_ff + 5'h1;
        if (tcnt_ff == 5'(BIT_CYCLES - 1)) begin
          nxt_tcnt = 5'h0;
          nxt_tsh = {1'b1, tsh_ff[9:1]};
          nxt_tbit = tbit_ff + 4'h1;
          if (tbit_ff == 4'(FRAME_BITS - 1)) begin
            nxt_tst = T_IDLE;
          end
        end
      end
      default: nxt_tst = T_IDLE;
    endcase
    // Idle: one in standard zero in infrared
    if (tst_ff != T_SHIFT) begin
      nxt_txo = !ir_mode;
    end else if (ir_mode) begin
      nxt_txo = !tsh_ff[0] && (tcnt_ff < 5'(IR_PULSE_CYCLES));
    end else begin
      nxt_txo = tsh_ff[0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Receiver: mid-bit sampling, infrared pulse inverted
  urt_rx_type rst_st_ff, nxt_rst_st;
  logic [4:0] rcnt_ff, nxt_rcnt;
  logic [3:0] rbit_ff, nxt_rbit;
  logic [8:0] rsh_ff, nxt_rsh;
  logic [4:0] quiet_ff, nxt_quiet, hold_ff, nxt_hold;
  logic rmode_ff;
  // Stretch short infrared pulses so mid-bit sampling sees them
  localparam int IR_HOLD_CYCLES = BIT_CYCLES - IR_PULSE_CYCLES - 1;
  wire logic rx_lvl = ir_mode ? !(rx2_ff || hold_ff != 5'h0) : rx2_ff;

  always_comb begin
    nxt_rst_st = rst_st_ff;
    nxt_rcnt = rcnt_ff;
    nxt_rbit = rbit_ff;
    nxt_rsh = rsh_ff;
    nxt_rxd = rxd_ff;
    rx_done = 1'b0;
    nxt_hold = (hold_ff != 5'h0) ? hold_ff - 5'h1 : 5'h0;
    if (ir_mode && rx2_ff) begin
      nxt_hold = 5'(IR_HOLD_CYCLES);
    end
    // Mode switch flips idle level; quiet time avoids a false start
    nxt_quiet = (quiet_ff != 5'h0) ? quiet_ff - 5'h1 : 5'h0;
    if (ir_mode != rmode_ff) begin
      nxt_quiet = 5'(BIT_CYCLES - 1);
    end
    case (rst_st_ff)
      R_IDLE: begin
        if (!rx_lvl && quiet_ff == 5'h0 && ir_mode == rmode_ff) begin
          nxt_rst_st = R_SHIFT;
          nxt_rcnt = 5'h0;
          nxt_rbit = 4'h0;
        end
      end
      R_SHIFT: begin
        nxt_rcnt = rcnt_ff + 5'h1;
        if (rcnt_ff == 5'(BIT_CYCLES / 2)) begin
          nxt_rsh = {rx_lvl, rsh_ff[8:1]};
          nxt_rbit = rbit_ff + 4'h1;
          if (rbit_ff == 4'(FRAME_BITS - 1)) begin
            nxt_rst_st = R_IDLE;
            nxt_rxd = rsh_ff[8:1];
            rx_done = rx_lvl; // Only well-framed bytes set ready; rxd_ff is loaded either way
          end
        end
        if (rcnt_ff == 5'(BIT_CYCLES - 1)) begin
          nxt_rcnt = 5'h0;
        end
      end
      default: nxt_rst_st = R_IDLE;
    endcase
  end

  // Registers: device reset restores control, state, flag and buffer-count flops; data, shift, bit-timing counter and mode-tracking flops keep their values
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mcr_ff <= RESET_BYTE;
      ier_ff <= RESET_BYTE;
      efr_ff <= RESET_BYTE;
      rdat_ff <= RESET_BYTE;
      oe_ff <= 1'b0;
      buf_cnt_ff <= 2'h0;
      buf_ff[0] <= '0;
      buf_ff[1] <= '0;
      rxd_ff <= '0;
      rxv_ff <= 1'b0;
      tst_ff <= T_IDLE;
      tsh_ff <= 10'h3FF;
      tcnt_ff <= 5'h0;
      tbit_ff <= 4'h0;
      txo_ff <= 1'b1;
      rst_st_ff <= R_IDLE;
      rcnt_ff <= 5'h0;
      rbit_ff <= 4'h0;
      rsh_ff <= 9'h000;
      quiet_ff <= 5'h0;
      hold_ff <= 5'h0;
      rmode_ff <= 1'b0;
    end else if (ce) begin
      if (srst) begin
        mcr_ff <= RESET_BYTE;
        ier_ff <= RESET_BYTE;
        efr_ff <= RESET_BYTE;
        oe_ff <= 1'b0;
        buf_cnt_ff <= 2'h0;
        rxv_ff <= 1'b0;
        tst_ff <= T_IDLE;
        txo_ff <= 1'b1; // Transmit high in reset
        rst_st_ff <= R_IDLE; // Receive ignored in reset
      end else begin
        mcr_ff <= nxt_mcr;
        ier_ff <= nxt_ier;
        efr_ff <= nxt_efr;
        rdat_ff <= nxt_rdat;
        oe_ff <= nxt_oe;
        buf_cnt_ff <= nxt_buf_cnt;
        buf_ff <= nxt_buf;
        rxd_ff <= nxt_rxd;
        rxv_ff <= nxt_rxv;
        tst_ff <= nxt_tst;
        tsh_ff <= nxt_tsh;
        tcnt_ff <= nxt_tcnt;
        tbit_ff <= nxt_tbit;
        txo_ff <= nxt_txo;
        rst_st_ff <= nxt_rst_st;
        rcnt_ff <= nxt_rcnt;
        rbit_ff <= nxt_rbit;
        rsh_ff <= nxt_rsh;
        quiet_ff <= nxt_quiet;
        hold_ff <= nxt_hold;
        rmode_ff <= ir_mode;
      end
    end
  end

  // Outputs straight from flops
  logic irq_ff, irq_oe_ff, rts_ff, dtr_ff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_ff <= 1'b0;
      irq_oe_ff <= 1'b0;
      rts_ff <= 1'b1;
      dtr_ff <= 1'b1;
    end else if (ce) begin
      irq_ff <= ier_ff[IE_CTS] && !cts2_ff; // Active high
      irq_oe_ff <= mcr_ff[MC_IRQ_OE] && !srst; // Else high-Z
      // Auto request-to-send deasserts when buffer space low
      rts_ff <= !(mcr_ff[MC_RTS] && !(efr_ff[EF_AUTO_RTS] && rxv_ff)) || srst;
      dtr_ff <= !mcr_ff[MC_DTR] || srst;
    end
  end

  assign bus.data_dev = rdat_ff;
  assign bus.data_dev_oe = oe_ff;
  assign bus.irq_o = irq_ff;
  assign bus.irq_oe = irq_oe_ff;
  assign tx_out = txo_ff;
  assign rts_n = rts_ff;
  assign dtr_n = dtr_ff;
endmodule : urt_device
`default_nettype wire

// >>> shared/urt_pkg.sv
`default_nettype none
package urt_pkg;
  // Register selects
  localparam logic [2:0] SEL_DATA = 3'h0;
  localparam logic [2:0] SEL_IRQ_EN = 3'h1;
  localparam logic [2:0] SEL_MODEM_CTRL = 3'h4;
  localparam logic [2:0] SEL_STATUS = 3'h5;
  localparam logic [2:0] SEL_MODEM_STAT = 3'h6;
  localparam logic [2:0] SEL_FEATURE = 3'h7;
  // Modem control fields
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_IRQ_OE = 3;
  localparam int MC_IR_SEL = 6;
  // Feature fields
  localparam int EF_AUTO_RTS = 6;
  localparam int EF_AUTO_CTS = 7;
  // Modem status fields
  localparam int MS_CTS = 4;
  localparam int MS_DSR = 5;
  localparam int MS_RI = 6;
  localparam int MS_CD = 7;
  localparam int IE_CTS = 7;
  localparam int ST_TX_EMPTY = 5;
  localparam int ST_RX_READY = 0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Clock and reset timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int RESET_MIN_NS = 40;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_CYCLES = 16;
  localparam int IR_PULSE_CYCLES = 3;
  localparam int FRAME_BITS = 10;
  localparam int STROBE_CYCLES = 3;
endpackage : urt_pkg
`default_nettype wire

// >>> shared/urt_bus_if.sv
`default_nettype none
interface urt_bus_if;
  logic cs_n;
  logic read_strobe_n;
  logic write_strobe_n;
  logic [2:0] reg_select;
  logic [7:0] data_host;
  logic [7:0] data_dev;
  logic data_dev_oe;
  logic irq_o;
  logic irq_oe;
  logic bus_isolate_in;
  logic hw_reset;
  modport device (input cs_n, read_strobe_n, write_strobe_n, reg_select, data_host, bus_isolate_in, hw_reset,
    output data_dev, data_dev_oe, irq_o, irq_oe);
  modport host (output cs_n, read_strobe_n, write_strobe_n, reg_select, data_host, bus_isolate_in, hw_reset,
    input data_dev, data_dev_oe, irq_o, irq_oe);
endinterface : urt_bus_if
`default_nettype wire

// >>> logic/urt_host.sv
`default_nettype none
module urt_host
  import urt_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  urt_bus_if.host bus,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [2:0] req_sel,
  input wire logic [7:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic irq_seen,
  input wire logic isolate_req,
  input wire logic reset_req
);
  typedef enum logic [1:0] {H_IDLE, H_STROBE, H_DONE} urt_hst_type;
  urt_hst_type st_ff, nxt_st;
  logic [3:0] cnt_ff, nxt_cnt;
  logic wr_ff, nxt_wr;
  logic [2:0] sel_ff, nxt_sel;
  logic [7:0] wd_ff, nxt_wd;
  logic rsp_ff, nxt_rsp;
  logic [7:0] rd_ff, nxt_rd;
  logic rdy_ff, nxt_rdy;
  logic irq_ff, iso_ff, rst_ff;
  logic [3:0] rcnt_ff, nxt_rcnt;

  ////////////////////////////////////////////////////////////////
  // Strobe sequencer: chip select held for whole cycle
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_wr = wr_ff;
    nxt_sel = sel_ff;
    nxt_wd = wd_ff;
    nxt_rsp = 1'b0;
    nxt_rd = rd_ff;
    nxt_rdy = 1'b0;
    case (st_ff)
      H_IDLE: begin
        if (req_valid && rdy_ff && !rst_ff) begin
          nxt_st = H_STROBE;
          nxt_wr = req_write;
          nxt_sel = req_sel;
          nxt_wd = req_wdata;
          nxt_cnt = 4'(STROBE_CYCLES);
        end else begin
          nxt_rdy = !rst_ff;
        end
      end
      H_STROBE: begin
        nxt_cnt = cnt_ff - 4'h1;
        if (cnt_ff == 4'h1) begin
          nxt_st = H_DONE;
        end
      end
      // Capture one cycle after strobe rise: device sync latency
      H_DONE: begin
        nxt_st = H_IDLE;
        nxt_rsp = !wr_ff;
        nxt_rd = bus.data_dev;
      end
      default: nxt_st = H_IDLE;
    endcase
  end

  // Reset pulse stretcher to meet minimum width
  always_comb begin
    nxt_rcnt = rcnt_ff;
    if (reset_req) begin
      nxt_rcnt = 4'(RESET_MIN_CYC + 1);
    end else if (rcnt_ff != 4'h0) begin
      nxt_rcnt = rcnt_ff - 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= H_IDLE;
      cnt_ff <= 4'h0;
      wr_ff <= 1'b0;
      sel_ff <= 3'h0;
      wd_ff <= 8'h00;
      rsp_ff <= 1'b0;
      rd_ff <= 8'h00;
      rdy_ff <= 1'b0;
      rcnt_ff <= 4'h0;
      irq_ff <= 1'b0;
      iso_ff <= 1'b0;
      rst_ff <= 1'b0;
    end else if (ce) begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      wr_ff <= nxt_wr;
      sel_ff <= nxt_sel;
      wd_ff <= nxt_wd;
      rsp_ff <= nxt_rsp;
      rd_ff <= nxt_rd;
      rdy_ff <= nxt_rdy;
      rcnt_ff <= nxt_rcnt;
      irq_ff <= bus.irq_oe && bus.irq_o;
      iso_ff <= isolate_req;
      rst_ff <= nxt_rcnt != 4'h0;
    end
  end

  // Pins: strobes only while chip select is low
  assign bus.cs_n = (st_ff == H_IDLE);
  assign bus.read_strobe_n = !(st_ff == H_STROBE && !wr_ff);
  assign bus.write_strobe_n = !(st_ff == H_STROBE && wr_ff);
  assign bus.reg_select = sel_ff;
  assign bus.data_host = wd_ff; // Device only reads it on writes
  assign bus.bus_isolate_in = iso_ff;
  assign bus.hw_reset = rst_ff;
  assign req_ready = rdy_ff;
  assign rsp_valid = rsp_ff;
  assign rsp_rdata = rd_ff;
  assign irq_seen = irq_ff;
endmodule : urt_host
`default_nettype wire

// >>> tb/urt_chk.sv
`default_nettype none
module urt_chk
  import urt_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [2:0] reg_select,
  input wire logic [7:0] data_host,
  input wire logic [7:0] data_dev,
  input wire logic data_dev_oe,
  input wire logic irq_o,
  input wire logic irq_oe,
  input wire logic bus_isolate_in,
  input wire logic hw_reset
);
  logic [3:0] rd_age_ff;
  logic [3:0] nxt_rd_age;
  // Age of the last selected read strobe, saturating so it never wraps
  always_comb begin
    nxt_rd_age = (rd_age_ff == 4'hF) ? rd_age_ff : rd_age_ff + 4'h1;
    if (!cs_n && !read_strobe_n) nxt_rd_age = 4'h0;
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) rd_age_ff <= 4'hF;
    else rd_age_ff <= nxt_rd_age;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  // Slack of five covers the two-flop strobe sync plus the output register
  a_drive_only_reads: assert property (data_dev_oe |-> rd_age_ff <= 4'h5)
    else $error("data bus driven outside a read");
  a_read_drives_bus: assert property ($fell(read_strobe_n) && !cs_n && !bus_isolate_in
    |-> ##[1:5] data_dev_oe)
    else $error("read did not drive the data bus");
  a_read_data_steady: assert property (data_dev_oe && $past(data_dev_oe) && $stable(reg_select)
    |-> $stable(data_dev))
    else $error("read data moved during a read");
  a_isolate_quiet: assert property (bus_isolate_in && $past(bus_isolate_in, 4) |-> !data_dev_oe)
    else $error("bus driven while isolated");
  a_irq_enable_set: assert property ($rose(write_strobe_n) && !cs_n && !bus_isolate_in
    && reg_select == SEL_MODEM_CTRL && data_host[MC_IRQ_OE] |-> ##[1:4] irq_oe)
    else $error("interrupt output not enabled");
  a_irq_enable_clr: assert property ($rose(write_strobe_n) && !cs_n && !bus_isolate_in
    && reg_select == SEL_MODEM_CTRL && !data_host[MC_IRQ_OE] |-> ##[1:4] !irq_oe)
    else $error("interrupt output not released");
  a_reset_clears: assert property ($fell(hw_reset) |-> !irq_oe && !data_dev_oe)
    else $error("outputs not cleared by reset");
  // Six cycles is RESET_MIN_CYC plus one
  a_reset_width: assert property ($rose(hw_reset) |-> hw_reset [*6])
    else $error("reset pulse too short");
  a_strobe_needs_cs: assert property (!read_strobe_n || !write_strobe_n |-> !cs_n)
    else $error("strobe without chip select");
  // Three low cycles is STROBE_CYCLES
  a_read_strobe_len: assert property ($fell(read_strobe_n) |-> !read_strobe_n [*3] ##1 read_strobe_n)
    else $error("read strobe width wrong");
  a_write_strobe_len: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*3] ##1 write_strobe_n)
    else $error("write strobe width wrong");
  c_read: cover property ($rose(data_dev_oe));
  c_irq: cover property ($rose(irq_oe) ##[1:40] irq_o);
  c_reset: cover property ($fell(hw_reset));
endmodule : urt_chk
`default_nettype wire

// >>> tb/urt_tb_top.sv
`default_nettype none
module urt_tb_top
  import urt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [2:0] req_sel = 3'h0;
  logic [7:0] req_wdata = 8'h00;
  logic isolate_req = 1'b0;
  logic reset_req = 1'b0;
  logic cts_n = 1'b1;
  logic dsr_n = 1'b1;
  logic cd_n = 1'b1;
  logic ri_n = 1'b1;
  logic req_ready, rsp_valid, irq_seen, tx_out, rx_in, rts_n, dtr_n;
  logic [7:0] rsp_rdata;
  logic [7:0] rd;
  int failures = 0;
  int checks = 0;
  urt_bus_if urt_bus_if_i ();
  urt_host urt_host_i (.mclk, .nrst, .ce(1'b1), .bus(urt_bus_if_i), .req_valid, .req_write, .req_sel,
    .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .irq_seen, .isolate_req, .reset_req);
  urt_device urt_device_i (.mclk, .nrst, .ce(1'b1), .bus(urt_bus_if_i), .rx_in, .cts_n, .dsr_n,
    .cd_n, .ri_n, .tx_out, .rts_n, .dtr_n);
  urt_chk urt_chk_i (.mclk, .nrst, .cs_n(urt_bus_if_i.cs_n), .read_strobe_n(urt_bus_if_i.read_strobe_n),
    .write_strobe_n(urt_bus_if_i.write_strobe_n), .reg_select(urt_bus_if_i.reg_select),
    .data_host(urt_bus_if_i.data_host), .data_dev(urt_bus_if_i.data_dev),
    .data_dev_oe(urt_bus_if_i.data_dev_oe), .irq_o(urt_bus_if_i.irq_o), .irq_oe(urt_bus_if_i.irq_oe),
    .bus_isolate_in(urt_bus_if_i.bus_isolate_in), .hw_reset(urt_bus_if_i.hw_reset));
  // Loopback keeps the receiver idle at whatever level the mode sends
  assign rx_in = tx_out;
  // Free-running clock
  always #(CLK_PERIOD_NS / 2) mclk = ~mclk;
  ////////////////////////////////////////
  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : cmp8
  task automatic cmp1(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %b got %b", n, e, g);
    end
  endtask : cmp1
  task automatic end_of_test;
    if (failures == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  // Inputs always move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  // Polls settled values between edges, so no race with the host's registers
  task automatic op(input logic w, input logic [2:0] s, input logic [7:0] d, output logic [7:0] r);
    int n;
    r = 8'h00;
    req_valid = 1'b1;
    req_write = w;
    req_sel = s;
    req_wdata = d;
    for (n = 0; req_ready !== 1'b1 && n < 60; n++) tick(1);
    tick(1);
    req_valid = 1'b0;
    if (!w) begin
      for (n = 0; rsp_valid !== 1'b1 && n < 60; n++) tick(1);
      r = rsp_rdata;
    end
    tick(2);
  endtask : op
  // Samples each bit in its middle; a missing start bit shows as a mismatch
  task automatic tx_frame(input logic [7:0] e);
    logic [9:0] f;
    for (int n = 0; tx_out !== 1'b0 && n < 400; n++) tick(1);
    tick(BIT_CYCLES / 2);
    for (int i = 0; i < FRAME_BITS; i++) begin
      f[i] = tx_out;
      tick(BIT_CYCLES);
    end
    cmp1("start", 1'b0, f[0]);
    cmp8("frame", e, f[8:1]);
    cmp1("stop", 1'b1, f[9]);
  endtask : tx_frame
  ////////////////////////////////////////
  task automatic t_reset;
    cmp1("tx", 1'b1, tx_out);
    cmp1("rts", 1'b1, rts_n);
    cmp1("dtr", 1'b1, dtr_n);
    cmp1("irq_oe", 1'b0, urt_bus_if_i.irq_oe);
    cmp1("bus_oe", 1'b0, urt_bus_if_i.data_dev_oe);
    op(1'b0, SEL_MODEM_CTRL, 8'h00, rd);
    cmp8("mc", RESET_BYTE, rd);
  endtask : t_reset
  task automatic t_modem_out;
    logic [7:0] v;
    v = (8'h01 << MC_DTR) | (8'h01 << MC_RTS) | (8'h01 << MC_IRQ_OE);
    op(1'b1, SEL_MODEM_CTRL, v, rd);
    op(1'b0, SEL_MODEM_CTRL, 8'h00, rd);
    cmp8("mc", v, rd);
    cmp1("rts", 1'b0, rts_n);
    cmp1("dtr", 1'b0, dtr_n);
    cmp1("irq_oe", 1'b1, urt_bus_if_i.irq_oe);
    op(1'b1, SEL_MODEM_CTRL, 8'h01 << MC_RTS, rd);
    tick(6);
    cmp1("dtr", 1'b1, dtr_n);
    cmp1("irq_oe", 1'b0, urt_bus_if_i.irq_oe);
  endtask : t_modem_out
  // DSR and RI stay low afterwards to show they do not disturb the link
  task automatic t_modem_in;
    cts_n = 1'b0;
    dsr_n = 1'b0;
    ri_n = 1'b0;
    op(1'b1, SEL_IRQ_EN, 8'h01 << IE_CTS, rd);
    op(1'b1, SEL_MODEM_CTRL, 8'h01 << MC_IRQ_OE, rd);
    op(1'b0, SEL_MODEM_STAT, 8'h00, rd);
    cmp8("ms", (8'h01 << MS_CTS) | (8'h01 << MS_DSR) | (8'h01 << MS_RI), rd & 8'hF0);
    cmp1("irq", 1'b1, urt_bus_if_i.irq_o);
    cmp1("irq_seen", 1'b1, irq_seen);
    cts_n = 1'b1;
    tick(6);
    cmp1("irq", 1'b0, urt_bus_if_i.irq_o);
    op(1'b1, SEL_IRQ_EN, 8'h00, rd);
    op(1'b1, SEL_MODEM_CTRL, 8'h00, rd);
  endtask : t_modem_in
  task automatic t_serial;
    fork
      op(1'b1, SEL_DATA, 8'hA5, rd);
      tx_frame(8'hA5);
    join
    tick(BIT_CYCLES);
    op(1'b0, SEL_STATUS, 8'h00, rd);
    cmp1("rx_ready", 1'b1, rd[ST_RX_READY]);
    op(1'b0, SEL_DATA, 8'h00, rd);
    cmp8("rx", 8'hA5, rd);
  endtask : t_serial
  // Clear-to-send held off stalls the sender with both buffer slots full
  task automatic t_flow;
    cts_n = 1'b1;
    op(1'b1, SEL_FEATURE, 8'h01 << EF_AUTO_CTS, rd);
    op(1'b1, SEL_DATA, 8'h11, rd);
    op(1'b1, SEL_DATA, 8'h22, rd);
    tick(3 * BIT_CYCLES);
    cmp1("tx held", 1'b1, tx_out);
    cts_n = 1'b0;
    tx_frame(8'h11);
    tx_frame(8'h22);
    tick(BIT_CYCLES);
    // Single receive holding register: the later byte overwrites
    op(1'b0, SEL_DATA, 8'h00, rd);
    cmp8("rx", 8'h22, rd);
    op(1'b0, SEL_STATUS, 8'h00, rd);
    cmp1("rx_ready", 1'b0, rd[ST_RX_READY]);
    op(1'b1, SEL_FEATURE, 8'h00, rd);
  endtask : t_flow
  task automatic t_ir;
    op(1'b1, SEL_MODEM_CTRL, 8'h01 << MC_IR_SEL, rd);
    tick(2 * BIT_CYCLES);
    cmp1("ir idle", 1'b0, tx_out);
    op(1'b1, SEL_DATA, 8'h3C, rd);
    tick((FRAME_BITS + 2) * BIT_CYCLES);
    cmp1("ir idle", 1'b0, tx_out);
    op(1'b0, SEL_DATA, 8'h00, rd);
    cmp8("ir rx", 8'h3C, rd);
    op(1'b1, SEL_MODEM_CTRL, 8'h00, rd);
  endtask : t_ir
  task automatic t_hw_reset;
    op(1'b1, SEL_MODEM_CTRL, 8'h01 << MC_RTS, rd);
    reset_req = 1'b1;
    tick(1);
    reset_req = 1'b0;
    tick(RESET_MIN_CYC + 6);
    cmp1("rts", 1'b1, rts_n);
    op(1'b0, SEL_MODEM_CTRL, 8'h00, rd);
    cmp8("mc", RESET_BYTE, rd);
  endtask : t_hw_reset
  task automatic t_isolate;
    isolate_req = 1'b1;
    tick(4);
    op(1'b1, SEL_MODEM_CTRL, 8'h01 << MC_DTR, rd);
    cmp1("dtr", 1'b1, dtr_n);
    isolate_req = 1'b0;
    tick(4);
    op(1'b0, SEL_MODEM_CTRL, 8'h00, rd);
    cmp8("mc", RESET_BYTE, rd);
  endtask : t_isolate
  ////////////////////////////////////////
  // Main sequence
  initial begin
    tick(12);
    nrst = 1'b1;
    tick(2);
    t_reset();
    t_modem_out();
    t_modem_in();
    t_serial();
    t_flow();
    t_ir();
    t_hw_reset();
    t_isolate();
    end_of_test();
  end
  // Run needs about 1000 cycles; the span leaves wide margin
  initial begin
    #(20000 * CLK_PERIOD_NS);
    failures++;
    end_of_test();
  end
endmodule : urt_tb_top
`default_nettype wire
